/* File: verilog/hub_eeprom_config_loader.sv */
// Hub configuration loader: reads and checks the EEPROM image
`timescale 1ns/1ps
module hub_eeprom_config_loader
   import hub_cfg_pkg::*;
#(
   parameter int IMAGE_BYTES = 128,
   parameter int QTR_COUNT = QTR_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reduced_pins,
   input wire logic three_wire_strap,
   input wire logic pwr_switch_req_n,
   input wire logic shared_pin_in,
   output logic shared_pin_out,
   output logic shared_pin_oe,
   output logic scl_oe,
   output logic sw_cs,
   output logic sw_clk,
   output logic sw_di,
   input wire logic sw_do,
   output logic downstream_power_switch_enable_n,
   output logic port1_amber_indicator_enable,
   output logic config_done,
   output logic config_from_eeprom,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [3:0] fixed_port_mask,
   output logic [2:0] port_count,
   output logic [7:0] max_power,
   output logic [7:0] vendor_str_len,
   output logic [7:0] product_str_len,
   output logic [7:0] serial_str_len,
   input wire logic [1:0] str_sel,
   input wire logic [5:0] str_idx,
   output logic [7:0] str_data
);
   // ==========================================
   // Local constants
   localparam logic [6:0] LAST_ADDR = 7'(IMAGE_BYTES - 1);
   localparam logic [7:0] QTR_LAST = 8'(QTR_COUNT - 1);
   localparam logic [5:0] SER_SPAN = 6'(LAST_ADDR - IDX_SER_FIRST + 7'h01);
   localparam int EVAL_WAIT = 4 * QTR_COUNT; // Evaluation lasts one whole bit

   // ==========================================
   // State record
   typedef struct packed {
      state_e st; // Loader state
      logic [7:0] q; // Quarter-bit divider
      logic [1:0] ph; // Quarter within a bit
      logic [3:0] bitn; // Bit within a byte or command
      logic [9:0] sh; // Shift register, sends from bit 9
      logic [1:0] seq; // I2C address phase
      logic [6:0] addr; // Image byte being read
      logic three_wire; // Three-wire EEPROM chosen
      logic eeprom_ack; // I2C EEPROM answered
      logic sda_meta, sda_sync; // Data line synchroniser
      logic do_meta, do_sync; // Three-wire data synchroniser
      logic red_meta, red_sync; // Variant strap synchroniser
      logic tw_meta, tw_sync; // Interface strap synchroniser
      logic scl_oe, sda_oe, cs, sclk, di; // Link drivers
      logic sh_oe, sh_out, pwr_n, amber_en; // Pin outputs
      logic done, from_ee; // Load status
      logic [15:0] vid, pid;
      logic [3:0] mask;
      logic [2:0] pcnt;
      logic [7:0] mpwr, vlen, plen, slen, sdata;
   } state_s;

   state_s r; // Registered state
   state_s n; // Next state
   logic [7:0] mem [0:IMAGE_BYTES-1]; // Image copy
   logic tick; // Quarter-bit enable
   logic [1:0] np; // Quarter being entered
   logic wr_en; // Store a received byte
   logic [7:0] chk_sum; // Expected checksum
   logic img_valid; // Image passed the check
   logic [6:0] str_base; // First byte of selected string
   logic [7:0] str_len; // Length of selected string
   logic [5:0] str_span; // Room for selected string
   logic [6:0] str_ptr; // Byte address of character

   assign tick = (r.q == QTR_LAST);
   assign np = r.ph + 2'h1;
   // Image checked against the sum of its id bytes plus one
   assign chk_sum = mem[IDX_VID_LO] + mem[IDX_VID_HI] + mem[IDX_PID_LO] + mem[IDX_PID_HI] + CHK_BIAS;
   assign img_valid = (r.three_wire || r.eeprom_ack) && (chk_sum == mem[IDX_IMAGE_CHECKSUM_BYTE]);

   // ==========================================
   // String field lookup
   always_comb begin
      case (str_sel)
         2'h0: begin // Vendor string
            str_base = IDX_VSTR_FIRST;
            str_len = r.vlen;
            str_span = STR_FIELD_SPAN;
         end
         2'h1: begin // Product string
            str_base = IDX_PSTR_FIRST;
            str_len = r.plen;
            str_span = STR_FIELD_SPAN;
         end
         2'h2: begin // Serial string
            str_base = IDX_SER_FIRST;
            str_len = r.slen;
            str_span = SER_SPAN;
         end
         default: begin // Nothing selected
            str_base = IDX_VID_LO;
            str_len = 8'h00;
            str_span = 6'h00;
         end
      endcase
      str_ptr = 7'(str_base + {1'b0, str_idx});
   end

   // ==========================================
   // Next-state logic
   always_comb begin
      n = r;
      wr_en = 1'b0;
      // Two flip-flops on the data and strap inputs, one on the power request
      n.sda_meta = shared_pin_in;
      n.sda_sync = r.sda_meta;
      n.do_meta = sw_do;
      n.do_sync = r.do_meta;
      n.red_meta = reduced_pins;
      n.red_sync = r.red_meta;
      n.tw_meta = three_wire_strap;
      n.tw_sync = r.tw_meta;
      n.pwr_n = pwr_switch_req_n;
      n.q = tick ? 8'h00 : r.q + 8'h01;
      if (tick) begin
         n.ph = np;
         // Sample the line in mid high phase
         if (np == PH_SAMPLE) begin
            case (r.st)
               ST_ACK: n.eeprom_ack = !r.sda_sync;
               ST_READ: n.sh = {r.sh[8:0], r.sda_sync};
               ST_WREAD: n.sh = {r.sh[8:0], r.do_sync};
               ST_START: n.sda_oe = 1'b1; // Start: data falls, clock high
               ST_STOP: n.sda_oe = 1'b0; // Stop: data rises, clock high
               default: ;
            endcase
         end
         // Bit boundary: advance and present next bit
         if (np == PH_SETUP) begin
            case (r.st)
               ST_IDLE: begin // Pick exactly one interface
                  n.addr = 7'h00;
                  n.bitn = 4'h0;
                  n.seq = SEQ_WR;
                  if (r.tw_sync && !r.red_sync) begin
                     n.three_wire = 1'b1;
                     n.amber_en = 1'b0;
                     n.cs = 1'b1;
                     n.sh = {SW_READ_CMD, 7'h00};
                     n.st = ST_CMD;
                  end else begin
                     n.amber_en = 1'b1;
                     n.st = ST_START;
                  end
               end
               ST_START: begin // Load device address
                  n.sh = {(r.seq == SEQ_RD) ? I2C_RD_ADDR : I2C_WR_ADDR, 2'h0};
                  n.bitn = 4'h0;
                  n.st = ST_SEND;
               end
               ST_SEND: begin
                  if (r.bitn == LAST_DATA_BIT) begin
                     n.bitn = 4'h0;
                     n.st = ST_ACK;
                  end else begin
                     n.bitn = r.bitn + 4'h1;
                     n.sh = {r.sh[8:0], 1'b0};
                  end
               end
               ST_ACK: begin
                  if (!r.eeprom_ack) begin // No EEPROM: defaults
                     n.st = ST_STOP;
                  end else if (r.seq == SEQ_WR) begin
                     n.seq = SEQ_WORD;
                     n.sh = {I2C_WORD_ADDR, 2'h0};
                     n.st = ST_SEND;
                  end else if (r.seq == SEQ_WORD) begin
                     n.seq = SEQ_RD;
                     n.st = ST_START;
                  end else begin
                     n.st = ST_READ;
                  end
               end
               ST_READ: begin
                  if (r.bitn == LAST_DATA_BIT) begin
                     wr_en = 1'b1;
                     n.bitn = 4'h0;
                     n.st = ST_MACK;
                  end else begin
                     n.bitn = r.bitn + 4'h1;
                  end
               end
               ST_MACK: begin
                  if (r.addr == LAST_ADDR) begin
                     n.st = ST_STOP;
                  end else begin
                     n.addr = r.addr + 7'h01;
                     n.st = ST_READ;
                  end
               end
               ST_STOP: n.st = ST_EVAL;
               ST_CMD: begin
                  if (r.bitn == LAST_CMD_BIT) begin
                     n.bitn = 4'h0;
                     n.st = ST_WREAD;
                  end else begin
                     n.bitn = r.bitn + 4'h1;
                     n.sh = {r.sh[8:0], 1'b0};
                  end
               end
               ST_WREAD: begin // Sequential read, never a write
                  n.bitn = (r.bitn == LAST_DATA_BIT) ? 4'h0 : r.bitn + 4'h1;
                  if (r.bitn == LAST_DATA_BIT) begin
                     wr_en = 1'b1;
                     if (r.addr == LAST_ADDR) begin
                        n.cs = 1'b0;
                        n.st = ST_EVAL;
                     end else begin
                        n.addr = r.addr + 7'h01;
                     end
                  end
               end
               ST_EVAL: begin // Settle all descriptor values
                  n.done = 1'b1;
                  n.st = ST_DONE;
                  n.from_ee = img_valid;
                  if (img_valid) begin
                     n.vid = {mem[IDX_VID_HI], mem[IDX_VID_LO]};
                     n.pid = {mem[IDX_PID_HI], mem[IDX_PID_LO]};
                     n.mask = mem[IDX_PORT_MASK][4:1];
                     n.pcnt = (mem[IDX_PORT_NUM] >= MIN_PORT_COUNT && mem[IDX_PORT_NUM] <= MAX_PORT_COUNT) ?
                        mem[IDX_PORT_NUM][2:0] : DEF_PORT_COUNT;
                     n.mpwr = (mem[IDX_MAX_POWER] <= MAX_POWER_LIMIT) ? mem[IDX_MAX_POWER] : DEF_MAX_POWER;
                     n.vlen = mem[IDX_VSTR_LEN];
                     n.plen = mem[IDX_PSTR_LEN];
                     n.slen = mem[IDX_SER_LEN];
                  end
               end
               ST_DONE: ;
               default: n.st = ST_IDLE;
            endcase
            // Drive data for the bit now starting
            case (n.st)
               ST_SEND: n.sda_oe = !n.sh[9];
               ST_MACK: n.sda_oe = (n.addr != LAST_ADDR);
               ST_STOP: n.sda_oe = 1'b1;
               default: n.sda_oe = 1'b0;
            endcase
            n.di = (n.st == ST_CMD) ? n.sh[9] : 1'b0;
         end
         // Clocks high in the two middle quarters; in the stop bit SCL is high in the last three
         case (n.st)
            ST_START, ST_SEND, ST_ACK, ST_READ, ST_MACK: n.scl_oe = !(np[0] ^ np[1]);
            ST_STOP: n.scl_oe = (np == PH_SETUP);
            default: n.scl_oe = 1'b0;
         endcase
         n.sclk = (n.st == ST_CMD || n.st == ST_WREAD) && (np[0] ^ np[1]);
      end
      // Shared pin: power duty only with no EEPROM in the reduced part
      if (r.red_sync && r.done && !r.eeprom_ack) begin
         n.sh_oe = 1'b1;
         n.sh_out = r.pwr_n;
      end else begin
         n.sh_oe = n.sda_oe;
         n.sh_out = 1'b0;
      end
      // Character lookup, zero outside the stored string
      if (r.from_ee && ({2'h0, str_idx} < str_len) && (str_idx < str_span)) begin
         n.sdata = mem[str_ptr];
      end else begin
         n.sdata = 8'h00;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.vid <= DEF_VENDOR_ID;
         r.pid <= DEF_PRODUCT_ID;
         r.mask <= DEF_PORT_MASK;
         r.pcnt <= DEF_PORT_COUNT;
         r.mpwr <= DEF_MAX_POWER;
         r.pwr_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // Image store
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[r.addr] <= r.sh[7:0];
      end
   end

   // ==========================================
   // Outputs
   assign shared_pin_out = r.sh_out;
   assign shared_pin_oe = r.sh_oe;
   assign scl_oe = r.scl_oe;
   assign sw_cs = r.cs;
   assign sw_clk = r.sclk;
   assign sw_di = r.di;
   assign downstream_power_switch_enable_n = r.pwr_n;
   assign port1_amber_indicator_enable = r.amber_en;
   assign config_done = r.done;
   assign config_from_eeprom = r.from_ee;
   assign vendor_id = r.vid;
   assign product_id = r.pid;
   assign fixed_port_mask = r.mask;
   assign port_count = r.pcnt;
   assign max_power = r.mpwr;
   assign vendor_str_len = r.vlen;
   assign product_str_len = r.plen;
   assign serial_str_len = r.slen;
   assign str_data = r.sdata;

   // ==========================================
   // Checks
   checksum_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(config_from_eeprom) |-> $past(chk_sum) == $past(mem[IDX_IMAGE_CHECKSUM_BYTE]))
      else $error("image taken with bad checksum");
   default_ids_a: assert property (@(posedge ref_clk) disable iff (rst)
      (config_done && !config_from_eeprom) |-> (vendor_id == DEF_VENDOR_ID && product_id == DEF_PRODUCT_ID))
      else $error("default ids not kept");
   id_mapping_a: assert property (@(posedge ref_clk) disable iff (rst)
      config_from_eeprom |-> vendor_id == {mem[IDX_VID_HI], mem[IDX_VID_LO]})
      else $error("vendor id not from bytes 0 and 1");
   port_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      config_done |-> fixed_port_mask == (config_from_eeprom ? mem[IDX_PORT_MASK][4:1] : DEF_PORT_MASK))
      else $error("port mask wrong");
   port_count_a: assert property (@(posedge ref_clk) disable iff (rst)
      port_count >= 3'h1 && port_count <= 3'h4)
      else $error("port count out of range");
   max_power_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!config_from_eeprom |-> max_power == DEF_MAX_POWER) and (max_power <= MAX_POWER_LIMIT))
      else $error("max power wrong");
   amber_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      (sw_cs || r.three_wire) |-> !port1_amber_indicator_enable)
      else $error("amber enabled with three-wire part");
   three_wire_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
      (r.st == ST_CMD && r.bitn == 4'h2 && r.ph != PH_SETUP) |-> !sw_di)
      else $error("three-wire opcode is not a read");
   one_iface_a: assert property (@(posedge ref_clk) disable iff (rst)
      sw_cs |-> (!scl_oe && !shared_pin_oe))
      else $error("both interfaces active");
   reduced_i2c_a: assert property (@(posedge ref_clk) disable iff (rst)
      (r.red_sync && $stable(r.red_sync)) |-> !sw_cs)
      else $error("three-wire used in reduced part");
   shared_sda_a: assert property (@(posedge ref_clk) disable iff (rst)
      (r.red_sync && r.eeprom_ack && config_done) |-> !shared_pin_out)
      else $error("shared pin left data duty");
   eval_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      (r.st == ST_EVAL) |-> ##[1:EVAL_WAIT] config_done)
      else $error("configuration not settled in time");
endmodule

/* File: verilog/hub_cfg_pkg.sv */
// Constants shared by the hub configuration loader
package hub_cfg_pkg;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 100; // Core clock period
   localparam int QTR_BIT_NS = 2500; // Quarter of one serial bit
   localparam int QTR_CYCLES = (QTR_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================
   // Image byte positions
   localparam logic [6:0] IDX_VID_LO = 7'h00;
   localparam logic [6:0] IDX_VID_HI = 7'h01;
   localparam logic [6:0] IDX_PID_LO = 7'h02;
   localparam logic [6:0] IDX_PID_HI = 7'h03;
   localparam logic [6:0] IDX_IMAGE_CHECKSUM_BYTE = 7'h04;
   localparam logic [6:0] IDX_PORT_MASK = 7'h06;
   localparam logic [6:0] IDX_PORT_NUM = 7'h07;
   localparam logic [6:0] IDX_MAX_POWER = 7'h08;
   localparam logic [6:0] IDX_VSTR_LEN = 7'h10;
   localparam logic [6:0] IDX_VSTR_FIRST = 7'h11;
   localparam logic [6:0] IDX_PSTR_LEN = 7'h40;
   localparam logic [6:0] IDX_PSTR_FIRST = 7'h41;
   localparam logic [6:0] IDX_SER_LEN = 7'h70;
   localparam logic [6:0] IDX_SER_FIRST = 7'h71;
   localparam logic [5:0] STR_FIELD_SPAN = 6'h2F; // Bytes 17..63 and 65..111
   // ==========================================
   // Checksum and defaults
   localparam logic [7:0] CHK_BIAS = 8'h01;
   localparam logic [15:0] DEF_VENDOR_ID = 16'h1234; // Arbitrary value
   localparam logic [15:0] DEF_PRODUCT_ID = 16'h5678; // Arbitrary value
   localparam logic [3:0] DEF_PORT_MASK = 4'h0;
   localparam logic [2:0] DEF_PORT_COUNT = 3'h4;
   localparam logic [7:0] MIN_PORT_COUNT = 8'h01;
   localparam logic [7:0] MAX_PORT_COUNT = 8'h04;
   localparam logic [7:0] DEF_MAX_POWER = 8'h32;
   localparam logic [7:0] MAX_POWER_LIMIT = 8'hFA;
   // ==========================================
   // Serial link encodings
   localparam logic [7:0] I2C_WR_ADDR = 8'hA0;
   localparam logic [7:0] I2C_RD_ADDR = 8'hA1;
   localparam logic [7:0] I2C_WORD_ADDR = 8'h00;
   localparam logic [2:0] SW_READ_CMD = 3'h6; // Start bit then read opcode
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] LAST_CMD_BIT = 4'h9;
   localparam logic [1:0] PH_SETUP = 2'h0;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] SEQ_WR = 2'h0;
   localparam logic [1:0] SEQ_WORD = 2'h1;
   localparam logic [1:0] SEQ_RD = 2'h2;
   // ==========================================
   // Loader states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000, ST_START = 4'b0001, ST_SEND = 4'b0010,
      ST_ACK = 4'b0011, ST_READ = 4'b0100, ST_MACK = 4'b0101,
      ST_STOP = 4'b0110, ST_CMD = 4'b0111, ST_WREAD = 4'b1000,
      ST_EVAL = 4'b1001, ST_DONE = 4'b1010
   } state_e;
endpackage

/* File: dv/cfg_eeprom_model.sv */
// Behavioural serial configuration memory with two-wire and three-wire ports
`timescale 1ns/1ps
module cfg_eeprom_model (
   input wire logic rst,
   input wire logic ack_en,
   input wire logic scl,
   input wire logic sda,
   input wire logic cs,
   input wire logic sclk,
   input wire logic di,
   output logic sda_low,
   output logic do_o
);
   // ==========================================
   // Storage and frame state
   logic [7:0] mem [128]; // Image bytes, filled by the bench
   logic [7:0] sh; // Two-wire shift register
   logic [9:0] cmd; // Three-wire command bits
   logic dbit; // Three-wire data bit
   logic act; // Two-wire frame open
   logic rd; // Two-wire read phase
   logic go_rd; // Read requested by address byte
   logic [6:0] ptr; // Read pointer
   int n; // Clock pulses in this byte
   int nb; // Bytes since start condition
   int k; // Three-wire clock count
   int nrd; // Bytes handed out since reset
   // Lines released at time zero
   initial begin
      sda_low = 1'b0;
      dbit = 1'b0;
   end
   // Reset clears the read and clock counters, the frame flag and the data drive
   always @(posedge rst) begin
      nrd = 0;
      k = 0;
      act = 1'b0;
      sda_low = 1'b0;
   end
   // Start condition, also repeated start
   always @(negedge sda) if (scl) begin
      act = 1'b1;
      // Clock fall closing the start must not count as a bit
      n = -1;
      nb = 0;
      rd = 1'b0;
      go_rd = 1'b0;
   end
   // Stop condition ends the frame
   always @(posedge sda) if (scl) begin
      act = 1'b0;
      sda_low = 1'b0;
   end
   // Sample on rising clock; a master nack ends the read
   always @(posedge scl) if (act) begin
      if (rd && n == 8 && sda)
         act = 1'b0;
      else if (n < 8)
         sh = {sh[6:0], sda};
   end
   // Drive ack or data only while the clock is low
   always @(negedge scl) if (act) begin
      n = n + 1;
      if (n == 8 && !rd) begin
         // Ack our address and every following write byte
         sda_low = ack_en && (nb > 0 || sh[7:1] == 7'h50);
         if (nb == 0)
            go_rd = sh[0];
         if (nb == 1)
            ptr = sh[6:0];
         nb = nb + 1;
      end else if (n == 8) begin
         // Release for the master acknowledge
         sda_low = 1'b0;
         ptr = ptr + 7'h01;
         nrd = nrd + 1;
      end else begin
         if (n == 9) begin
            n = 0;
            rd = go_rd;
         end
         sda_low = rd && !mem[ptr][7 - n];
      end
   end
   // Three-wire: take the command, count streamed bytes
   always @(posedge sclk) if (cs) begin
      if (k < 10)
         cmd = {cmd[8:0], di};
      else if ((k - 10) % 8 == 7)
         nrd = nrd + 1;
      k = k + 1;
   end
   // Answer only a read command, never store anything
   always @(negedge sclk) if (cs && k >= 10 && cmd == 10'h300)
      dbit = mem[((k - 10) / 8) % 128][7 - (k - 10) % 8];
   // Deselected output shows the inverse of the last data bit
   assign do_o = cs ? dbit : !dbit;
endmodule

/* File: dv/tb_hub_eeprom_config_loader.sv */
// Self-checking bench for the hub configuration loader
`timescale 1ns/1ps
module tb_hub_eeprom_config_loader;
   import hub_cfg_pkg::*;
   // ==========================================
   // Stimulus and observed signals
   logic ref_clk = 1'b0, rst = 1'b1, reduced_pins = 1'b0, three_wire_strap = 1'b0;
   logic pwr_switch_req_n = 1'b1, ack_en = 1'b1;
   logic [1:0] str_sel = 2'h3;
   logic [5:0] str_idx = 6'h00;
   logic shared_pin_out, shared_pin_oe, scl_oe, sw_cs, sw_clk, sw_di, sw_do, sda_low;
   logic downstream_power_switch_enable_n, port1_amber_indicator_enable, config_done, config_from_eeprom;
   logic cs_seen, i2c_seen;
   logic [15:0] vendor_id, product_id;
   logic [3:0] fixed_port_mask;
   logic [2:0] port_count;
   logic [7:0] max_power, vendor_str_len, product_str_len, serial_str_len, str_data;
   int fail_count = 0;
   int checked = 0;
   // Open-drain lines with pull-ups
   wire scl = !scl_oe;
   wire sda = !((shared_pin_oe && !shared_pin_out) || sda_low);
   // Core clock, 100 ns period
   initial forever #50 ref_clk = !ref_clk;
   hub_eeprom_config_loader #(.QTR_COUNT(2)) u_hub_eeprom_config_loader (
      .ref_clk, .rst, .reduced_pins, .three_wire_strap, .pwr_switch_req_n, .shared_pin_in(sda),
      .shared_pin_out, .shared_pin_oe, .scl_oe, .sw_cs, .sw_clk, .sw_di, .sw_do,
      .downstream_power_switch_enable_n, .port1_amber_indicator_enable, .config_done, .config_from_eeprom,
      .vendor_id, .product_id, .fixed_port_mask, .port_count, .max_power, .vendor_str_len,
      .product_str_len, .serial_str_len, .str_sel, .str_idx, .str_data);
   cfg_eeprom_model u_cfg_eeprom_model (.rst, .ack_en, .scl, .sda, .cs(sw_cs), .sclk(sw_clk), .di(sw_di),
      .sda_low, .do_o(sw_do));
   // Record which link was ever used since reset
   always @(posedge ref_clk) begin
      if (rst) begin
         cs_seen <= 1'b0;
         i2c_seen <= 1'b0;
      end else begin
         if (sw_cs)
            cs_seen <= 1'b1;
         if (scl_oe)
            i2c_seen <= 1'b1;
      end
   end
   // ==========================================
   // Compare and report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // One load: build image, reset, wait, check everything
   task automatic run(input logic red, input logic tw3, input logic ack, input int kind);
      logic [7:0] m [128];
      logic v, tw;
      logic [7:0] e;
      int lim;
      for (int i = 0; i < 128; i++)
         m[i] = (kind == 4) ? 8'hFF : 8'($urandom);
      if (kind != 4) begin
         m[6] = {3'h0, 4'($urandom), 1'h0};
         m[7] = (kind == 2) ? 8'h01 : (kind == 3) ? 8'h05 : (kind == 5) ? 8'h00 : 8'($urandom_range(4, 1));
         m[8] = (kind == 2) ? 8'hFA : (kind == 3) ? 8'hFB : (kind == 5) ? 8'h00 : 8'($urandom_range(250));
         m[16] = 8'($urandom_range(50));
         m[64] = 8'($urandom_range(50));
         m[112] = 8'($urandom_range(20));
         m[4] = m[0] + m[1] + m[2] + m[3] + 8'h01 + 8'(kind == 1);
      end
      for (int i = 0; i < 128; i++)
         u_cfg_eeprom_model.mem[i] = m[i];
      @(posedge ref_clk);
      reduced_pins <= red;
      three_wire_strap <= tw3;
      ack_en <= ack;
      rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      lim = 0;
      while (config_done !== 1'b1 && lim < 20000) begin
         @(negedge ref_clk);
         lim++;
      end
      if (lim == 20000) begin
         fail_count++;
         final_report();
      end
      tw = tw3 && !red;
      v = (tw || ack) && (m[4] === 8'(m[0] + m[1] + m[2] + m[3] + 8'h01));
      chk(16'(u_cfg_eeprom_model.nrd), (tw || ack) ? 16'h0080 : 16'h0000);
      chk(16'(config_from_eeprom), 16'(v));
      chk(vendor_id, v ? {m[1], m[0]} : DEF_VENDOR_ID);
      chk(product_id, v ? {m[3], m[2]} : DEF_PRODUCT_ID);
      chk(16'(fixed_port_mask), v ? 16'(m[6][4:1]) : 16'h0000);
      chk(16'(port_count), (v && m[7] >= 8'h01 && m[7] <= 8'h04) ? 16'(m[7]) : 16'h0004);
      chk(16'(max_power), (v && m[8] <= 8'hFA) ? 16'(m[8]) : 16'h0032);
      chk(16'(vendor_str_len), v ? 16'(m[16]) : 16'h0000);
      chk(16'(product_str_len), v ? 16'(m[64]) : 16'h0000);
      chk(16'(serial_str_len), v ? 16'(m[112]) : 16'h0000);
      chk(16'(port1_amber_indicator_enable), 16'(!tw));
      chk(16'(cs_seen), 16'(tw));
      chk(16'(i2c_seen), 16'(!tw));
      if (tw)
         chk(16'(u_cfg_eeprom_model.cmd), 16'h0300);
      // Every character slot of every string, including past the length
      for (int s = 0; s < 4; s++) begin
         for (int i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            str_sel <= 2'(s);
            str_idx <= 6'(i);
            @(posedge ref_clk);
            @(negedge ref_clk);
            e = 8'h00;
            if (v && s < 3 && i < m[16 + 48 * s] && i < (s == 2 ? 15 : 47))
               e = m[17 + 48 * s + i];
            chk(16'(str_data), 16'(e));
         end
      end
      // Power request must not take the shared pin while a memory answers
      @(posedge ref_clk);
      pwr_switch_req_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(downstream_power_switch_enable_n), 16'h0000);
      chk(16'(shared_pin_oe), 16'(red && !ack));
      @(posedge ref_clk);
      pwr_switch_req_n <= 1'b1;
      // Released request shows on the pin only in power duty
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(shared_pin_out), 16'(red && !ack));
   endtask
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'hE03A));
      run(1'b0, 1'b0, 1'b1, 0);
      run(1'b0, 1'b0, 1'b1, 1);
      run(1'b0, 1'b0, 1'b1, 2);
      run(1'b0, 1'b0, 1'b1, 3);
      run(1'b0, 1'b0, 1'b1, 5);
      run(1'b0, 1'b0, 1'b0, 0);
      run(1'b0, 1'b1, 1'b0, 0);
      run(1'b0, 1'b1, 1'b1, 4);
      run(1'b1, 1'b1, 1'b1, 0);
      run(1'b1, 1'b0, 1'b0, 0);
      final_report();
   end
endmodule
